// file: design/suspend_wake_sequencer.sv
// How it works
// RULE1: With sleep enabled, request falling while suspended starts wake.
// RULE2: Multi-wake: request low, then any unmasked wake pin high; already high wakes now.
// RULE3: Reconfigure pulse low or power cycle resets the sequencer and restarts.
// RULE4: Valid wake re-enables inputs after the input release delay; code re-enables them on entering in_wait, before the delay.
// RULE5: Global init pulse on wake only when wake_global_init is set.
// RULE6: Two release counters start only once wake status is high.
// RULE7: Sleep request ignored unless sleep feature enabled; disabled by default.
// RULE8: Mode off frees status pin; filter_on_value mode glitch filters; filter_off_value bypasses.
// RULE9: Without multi-wake only the request pin controls suspend.
// RULE10: Eight wake pins gated by eight-bit mask, set bit enables pin.
// RULE11: Enabled wake pins trigger on high level or rising edge.
// RULE12: Single-ended outputs take their configured suspend behaviour.
// RULE13: Differential outputs go high impedance; hold-last not supported.
// RULE14: Pseudo-differential pairs are two single-ended pins, configured consistently.
// RULE15: After store lock delay storage is write-protected throughout suspend.
// RULE16: Writes re-enabled when the store release count expires.
// RULE17: Store enable removal comes first, before status and input changes.
// RULE18: Without handshake storage may update during the store lock delay.
// RULE19: Handshake: user logic stops clocks then asserts sleep_ack.
// RULE20: User logic should synchronise wake to its own clock.
// RULE21: Request should be held low through power-up and configuration.
// RULE22: Only constraint-file enable reserves the status pin.
// RULE23: Status pin low while suspended, high again on wake.
// RULE24: Default output release four cycles after status high.
// RULE25: Default store release five cycles after status high.
// RULE26: Release counts programmable from one to 1024.
// RULE27: Request and wake pins synchronised before use.
// RULE28: Release counters reset to zero at each suspend entry.
`include "suspend_consts.svh"
module suspend_wake_sequencer
	import suspend_pkg::*;
#(
	parameter int NPINS = 4,
	parameter int NDIFF = 2
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic                      reconfig_n,
	input  wire logic                      sleep_pin,
	input  wire logic [7:0]                wake_pin,
	input  wire logic                      status_reserved,
	input  wire seq_cfg_t                  cfg,
	input  wire logic                      sleep_ack,
	output logic                           sleep_req,
	input  wire pin_suspend_t [NPINS-1:0]  pin_mode,
	input  wire logic [NPINS-1:0]          user_out,
	input  wire logic [NPINS-1:0]          user_oe_n,
	output logic [NPINS-1:0]               pad_out,
	output logic [NPINS-1:0]               pad_oe_n,
	output logic [NPINS-1:0]               pad_pull_high,
	output logic [NPINS-1:0]               pad_pull_low,
	output logic [NPINS-1:0]               pad_hold,
	input  wire logic [NDIFF-1:0]          diff_out,
	input  wire logic [NDIFF-1:0]          diff_oe_n,
	output logic [NDIFF-1:0]               diff_pad_out,
	output logic [NDIFF-1:0]               diff_pad_oe_n,
	output logic                           wake_status_out,
	output logic                           wake_status_oe_n,
	output seq_ctl_t                       ctl
);
	typedef enum logic [2:0] {run_st, ack_wait, lock_wait, low_wait, asleep, in_wait, rel_wait}
		state_t;
	state_t      state;
	state_t      next_state;
	logic [3:0]  timer;
	logic        sleep_req_s;
	logic [7:0]  wake_s;
	logic [7:0]  wake_prev;
	logic [`FILTER_LEN-1:0] filt;
	logic        sleep_req_f;
	logic [NPINS-1:0] last_val;
	logic        out_done;
	logic        store_done;
	logic        reset_any;
	logic        req_prev;

	// Reconfigure pulse acts like a reset
	assign reset_any = rst | ~reconfig_n; // RULE3

	pin_sync3 #(.W(1)) u_sleep_req_sync (.ref_clk(ref_clk), .rst(reset_any), .ce(ce), .din(sleep_pin),
		.dout(sleep_req_s)); // RULE27
	pin_sync3 #(.W(8)) u_wake_sync (.ref_clk(ref_clk), .rst(reset_any), .ce(ce), .din(wake_pin),
		.dout(wake_s)); // RULE27

	wire sleep_en   = (cfg.mode != sleep_off); // RULE7
	wire filt_high  = &filt;
	wire filt_low   = ~|filt;
	always_ff @(posedge ref_clk or posedge reset_any)
	begin
		if (reset_any)
		begin
			filt   <= '0;
			sleep_req_f <= 1'b0;
			wake_prev <= 8'h00;
		end
		else if (ce)
		begin
			filt      <= {filt[`FILTER_LEN-2:0], sleep_req_s};
			wake_prev <= wake_s;
			if (filt_high)
				sleep_req_f <= 1'b1;
			else if (filt_low)
				sleep_req_f <= 1'b0;
		end
	end
	wire req_level = sleep_en && ((cfg.mode == filter_on_value) ? sleep_req_f : sleep_req_s); // RULE8 RULE7

	wire [7:0] wake_en  = wake_s & cfg.wake_mask; // RULE10
	wire [7:0] wake_new = wake_s & ~wake_prev & cfg.wake_mask;
	// Edge mode still accepts a pin that is already high as the request falls
	wire req_fell  = req_prev && !req_level; // RULE2
	wire wake_hit  = cfg.wake_edge ? (|wake_new || (req_fell && |wake_en)) : |wake_en; // RULE11
	wire wake_cond = !req_level && (!cfg.multi_wake || wake_hit); // RULE1 RULE2 RULE9

	wire timer_zero = (timer == 4'h0);
	always_comb
	begin
		next_state = state;
		unique case (state)
			run_st:
				if (req_level)
					next_state = cfg.use_handshake ? ack_wait : lock_wait;
			ack_wait:
				if (!req_level)
					next_state = run_st;
				else if (sleep_ack)
					next_state = lock_wait; // RULE19
			lock_wait:
				if (timer_zero)
					next_state = low_wait;
			low_wait:
				if (timer_zero)
					next_state = asleep;
			asleep:
				if (wake_cond)
					next_state = in_wait;
			in_wait:
				if (timer_zero)
					next_state = rel_wait;
			rel_wait:
				if (out_done && store_done)
					next_state = run_st;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset_any)
	begin
		if (reset_any)
		begin
			state <= run_st;
			timer <= 4'h0;
		end
		else if (ce)
		begin
			state <= next_state;
			if (next_state != state)
				unique case (next_state)
					lock_wait: timer <= 4'(`STORE_LOCK_CYCLES - 1);
					low_wait:  timer <= 4'(`STATUS_LOW_CYCLES - 1);
					in_wait:   timer <= 4'(`INPUT_RELEASE_CYCLES - 1); // RULE4
					default:   timer <= 4'h0;
				endcase
			else if (!timer_zero)
				timer <= timer - 4'h1;
		end
	end

	wire entering = (state == run_st) && (next_state != run_st);
	release_counter u_out_cnt (.ref_clk(ref_clk), .rst(reset_any), .ce(ce),
		.clear(entering), .run(state == rel_wait), .target(cfg.output_release_count),
		.done(out_done)); // RULE6 RULE24 RULE26 RULE28
	release_counter u_store_cnt (.ref_clk(ref_clk), .rst(reset_any), .ce(ce),
		.clear(entering), .run(state == rel_wait), .target(cfg.store_release_count),
		.done(store_done)); // RULE6 RULE25 RULE26 RULE16

	wire locked    = (state inside {low_wait, asleep, in_wait}) ||
		(state == rel_wait && !store_done); // RULE15 RULE17
	wire pins_susp = (state inside {asleep, in_wait}) || (state == rel_wait && !out_done); // RULE12
	wire inputs_off = (state == asleep); // RULE4
	wire status_hi = !(state inside {asleep, in_wait}); // RULE23

	always_ff @(posedge ref_clk or posedge reset_any)
	begin
		if (reset_any)
		begin
			last_val  <= '0;
			sleep_req <= 1'b0;
			req_prev  <= 1'b0;
			ctl       <= '0;
		end
		else if (ce)
		begin
			if (entering)
				last_val <= user_out;
			sleep_req            <= req_level;
			req_prev             <= req_level;
			ctl.store_enable     <= !locked; // RULE15 RULE18
			ctl.inputs_enable    <= !inputs_off;
			ctl.outputs_normal   <= !pins_susp;
			ctl.global_init      <= cfg.wake_global_init &&
				(state == in_wait) && timer_zero; // RULE5
			ctl.wake_status      <= status_hi;
			ctl.suspended        <= (state != run_st);
		end
	end

	// Status pin driven only when reserved and sleep enabled
	assign wake_status_out  = ctl.wake_status;
	assign wake_status_oe_n = !(sleep_en && status_reserved); // RULE22 RULE8

	always_comb
	begin
		for (int i = 0; i < NPINS; i++)
		begin
			pad_out[i]       = user_out[i];
			pad_oe_n[i]      = user_oe_n[i];
			pad_pull_high[i] = 1'b0;
			pad_pull_low[i]  = 1'b0;
			pad_hold[i]      = 1'b0;
			if (!ctl.outputs_normal)
			begin
				pad_out[i]       = last_val[i];
				pad_oe_n[i]      = (pin_mode[i] != drive_last); // RULE12 RULE14
				pad_pull_high[i] = (pin_mode[i] == hiz_pull_high);
				pad_pull_low[i]  = (pin_mode[i] == hiz_pull_low);
				pad_hold[i]      = (pin_mode[i] == hiz_bus_hold);
			end
		end
	end
	assign diff_pad_out  = diff_out;
	assign diff_pad_oe_n = ctl.outputs_normal ? diff_oe_n : {NDIFF{1'b1}}; // RULE13

	AST_NO_SLEEP_WHEN_OFF: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE7
		(ce && cfg.mode == sleep_off && state == run_st) |=> state == run_st)
		else $error("sleep entered while disabled");
	AST_LOCK_FIRST: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE17
		(ce && state == lock_wait && next_state == low_wait) |=> ctl.wake_status)
		else $error("status changed before lock");
	AST_STATUS_LOW: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE23
		(ce && state == asleep) |=> !ctl.wake_status)
		else $error("status not low in suspend");
	AST_LOCKED_ASLEEP: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE15
		(ce && state == asleep) |=> !ctl.store_enable)
		else $error("store not locked in suspend");
	AST_ACK_NEEDED: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE19
		(ce && state == ack_wait && !sleep_ack) |=> state inside {ack_wait, run_st})
		else $error("entry without ack");
	AST_COUNT_FRESH: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE28
		(ce && entering) |=> !out_done && !store_done)
		else $error("counters not cleared");
	AST_WAKE_MULTI: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE2
		(ce && state == asleep && cfg.multi_wake && req_level) |=> state == asleep)
		else $error("woke with request high");
	AST_DIFF_HIZ: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE13
		!ctl.outputs_normal |-> &diff_pad_oe_n)
		else $error("diff driven in suspend");
	AST_GINIT: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE5
		(ce && !cfg.wake_global_init) |=> !ctl.global_init)
		else $error("global init without option");

	// Entry steps: store lock, then status low, then suspended
	sequence s_lock_phase;
		(state == lock_wait) [*3] ##1 (state == low_wait) [*2] ##1 (state == asleep);
	endsequence

	// Wake steps: fixed input release delay, then release counting
	sequence s_release_phase;
		(state == in_wait) [*5] ##1 (state == rel_wait);
	endsequence

	AST_ENTRY_STEPS: assert property (@(posedge ref_clk) disable iff (reset_any || !ce) // RULE17
		(state inside {run_st, ack_wait} && next_state == lock_wait) |=> s_lock_phase)
		else $error("entry steps out of order");
	AST_INPUT_RELEASE: assert property (@(posedge ref_clk) disable iff (reset_any || !ce) // RULE4
		(state == asleep && next_state == in_wait) |=> s_release_phase)
		else $error("input release delay wrong");
	AST_INPUTS_OFF: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE4
		(ce && state == asleep) |=> !ctl.inputs_enable)
		else $error("inputs enabled in suspend");
	AST_STATUS_BACK: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE23
		(ce && state == rel_wait) |=> ctl.wake_status)
		else $error("status not high on wake");
	AST_GINIT_PULSE: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE5
		(ce && ctl.global_init) |=> !ctl.global_init)
		else $error("global init longer than one cycle");
	AST_STATUS_FREE: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE8
		(cfg.mode == sleep_off) |-> wake_status_oe_n)
		else $error("status pin driven while sleep off");
	AST_MASKED_NO_WAKE: assert property (@(posedge ref_clk) disable iff (reset_any) // RULE10
		(ce && state == asleep && cfg.multi_wake && (wake_s & cfg.wake_mask) == 8'h00)
		|=> state == asleep)
		else $error("woke with no enabled pin high");
endmodule

// file: design/suspend_consts.svh
`ifndef SUSPEND_CONSTS_SVH
`define SUSPEND_CONSTS_SVH
`define CLK_PERIOD_NS          8
`define INPUT_RELEASE_DELAY_NS 40
`define INPUT_RELEASE_CYCLES   ((`INPUT_RELEASE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STORE_LOCK_DELAY_NS    24
`define STORE_LOCK_CYCLES      ((`STORE_LOCK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STATUS_LOW_DELAY_NS    16
`define STATUS_LOW_CYCLES      ((`STATUS_LOW_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUTPUT_RELEASE_DEFAULT 11'h004
`define STORE_RELEASE_DEFAULT  11'h005
`define RELEASE_COUNT_MAX      11'h400
`define WAKE_MASK_DEFAULT      8'hff
`define FILTER_LEN             3
`endif

// file: design/suspend_pkg.sv
package suspend_pkg;
	typedef enum logic [1:0] {sleep_off, filter_on_value, filter_off_value} sleep_mode_t;
	typedef enum logic [2:0] {drive_last, hiz_plain, hiz_pull_high, hiz_pull_low, hiz_bus_hold}
		pin_suspend_t;
	typedef struct packed {
		sleep_mode_t mode;
		logic        multi_wake;
		logic [7:0]  wake_mask;
		logic        wake_edge;
		logic        wake_global_init;
		logic        use_handshake;
		logic [10:0] output_release_count;
		logic [10:0] store_release_count;
	} seq_cfg_t;
	typedef struct packed {
		logic store_enable;
		logic inputs_enable;
		logic outputs_normal;
		logic global_init;
		logic wake_status;
		logic suspended;
	} seq_ctl_t;
endpackage

// file: design/pin_sync3.sv
module pin_sync3 #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire  [W-1:0] agree = ~(s2 ^ s3);
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end
		else if (ce)
		begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= (agree & s2) | (~agree & dout);
		end
	end
endmodule

// file: design/release_counter.sv
module release_counter (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        clear,
	input  wire logic        run,
	input  wire logic [10:0] target,
	output logic             done
);
	logic [10:0] count;
	wire  [10:0] next_count = count + 11'h001;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			count <= 11'h000;
			done  <= 1'b0;
		end
		else if (ce)
		begin
			if (clear)
			begin
				count <= 11'h000;
				done  <= 1'b0;
			end
			else if (run && !done)
			begin
				count <= next_count;
				done  <= (next_count >= target);
			end
		end
	end
endmodule

// file: sim/user_logic_model.sv
module user_logic_model (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic sleep_req,
	output logic      sleep_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	// Stops its clocks first, then acknowledges; holds ack until request drops
	// Runs on the sequencer clock, so its wake is already synchronised
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || !sleep_req)
		begin
			sleep_ack <= 1'b0;
			n <= 0;
		end
		else if (n == (slow ? 12 : 2))
			sleep_ack <= 1'b1;
		else
			n <= n + 1;
	end
endmodule

// file: sim/suspend_wake_sequencer_tb_top.sv
module suspend_wake_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import suspend_pkg::*;
	localparam int SE = 5, IE = 4, ON = 3, WS = 1, SU = 0;
	logic         ref_clk, rst, ce, reconfig_n, sleep_pin, status_reserved;
	logic         sleep_ack, sleep_req, slow, wake_status_out, wake_status_oe_n, seen_init;
	logic [7:0]   wake_pin;
	seq_cfg_t     cfg;
	seq_ctl_t     ctl;
	pin_suspend_t [4:0] pin_mode;
	logic [4:0]   user_out, user_oe_n, pad_out, pad_oe_n, pad_pull_high, pad_pull_low, pad_hold;
	logic [1:0]   diff_out, diff_oe_n, diff_pad_out, diff_pad_oe_n;
	int           fails, total_checks, cycles, n;
	suspend_wake_sequencer #(.NPINS(5), .NDIFF(2)) dut (.ref_clk, .rst, .ce, .reconfig_n,
		.sleep_pin, .wake_pin, .status_reserved, .cfg, .sleep_ack, .sleep_req, .pin_mode,
		.user_out, .user_oe_n, .pad_out, .pad_oe_n, .pad_pull_high, .pad_pull_low, .pad_hold,
		.diff_out, .diff_oe_n, .diff_pad_out, .diff_pad_oe_n, .wake_status_out,
		.wake_status_oe_n, .ctl);
	user_logic_model model (.ref_clk, .rst, .slow, .sleep_req, .sleep_ack);
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (ctl.global_init === 1'b1)
			seen_init <= 1'b1;
		if (cycles == 20000)
		begin
			fails++;
			test_done();
		end
	end
	task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_bit(input int idx, input logic val);
		n = 0;
		while (ctl[idx] !== val && n < 3000)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n == 3000)
			check("wait", 11'(idx), 11'h7ff);
	endtask
	task automatic go_sleep();
		@(posedge ref_clk);
		sleep_pin <= 1'b1;
		wait_bit(SE, 1'b0);
		check("status at lock", ctl.wake_status, 1'b1);
		check("inputs at lock", ctl.inputs_enable, 1'b1);
		wait_bit(WS, 1'b0);
		check("status asleep", wake_status_out, 1'b0);
		check("store asleep", ctl.store_enable, 1'b0);
	endtask
	task automatic finish_wake(input int o, input int s);
		wait_bit(WS, 1'b1);
		check("inputs at status", ctl.inputs_enable, 1'b1);
		check("store at status", ctl.store_enable, 1'b0);
		wait_bit(ON, 1'b1);
		check("output count", 11'(n), 11'(o));
		wait_bit(SE, 1'b1);
		check("store count", 11'(n), 11'(s - o));
	endtask
	task automatic t_disabled();
		check("status pin free", wake_status_oe_n, 1'b1);
		sleep_pin <= 1'b1;
		repeat (30) @(posedge ref_clk);
		#1;
		check("ignored request", ctl.suspended, 1'b0);
		check("store kept", ctl.store_enable, 1'b1);
		sleep_pin <= 1'b0;
		repeat (10) @(posedge ref_clk);
	endtask
	task automatic t_outputs();
		cfg.mode <= filter_on_value;
		repeat (2) @(posedge ref_clk);
		#1;
		check("status pin reserved", wake_status_oe_n, 1'b0);
		go_sleep();
		@(posedge ref_clk);
		user_out <= 5'h0a;
		repeat (2) @(posedge ref_clk);
		#1;
		check("pad oe", pad_oe_n, 5'h1e);
		check("pad last", pad_out[0], 1'b1);
		check("pull high", pad_pull_high, 5'h04);
		check("pull low", pad_pull_low, 5'h08);
		check("keeper", pad_hold, 5'h10);
		check("diff hiz", diff_pad_oe_n, 2'h3);
		check("diff data", diff_pad_out, 2'h1);
		seen_init = 1'b0;
		sleep_pin <= 1'b0;
		finish_wake(4, 5);
		check("no init", seen_init, 1'b0);
		check("pad normal", pad_oe_n, 5'h00);
	endtask
	task automatic t_counts();
		cfg.wake_global_init <= 1'b1;
		cfg.output_release_count <= 11'h001;
		cfg.store_release_count <= 11'h400;
		go_sleep();
		seen_init = 1'b0;
		sleep_pin <= 1'b0;
		finish_wake(1, 1024);
		check("init pulse", seen_init, 1'b1);
		cfg.wake_global_init <= 1'b0;
		cfg.output_release_count <= 11'h004;
		cfg.store_release_count <= 11'h005;
	endtask
	task automatic t_multi();
		cfg.multi_wake <= 1'b1;
		cfg.wake_mask <= 8'h0f;
		go_sleep();
		wake_pin <= 8'h10;
		sleep_pin <= 1'b0;
		repeat (30) @(posedge ref_clk);
		#1;
		check("masked pin", ctl.suspended, 1'b1);
		wake_pin <= 8'h11;
		finish_wake(4, 5);
		wake_pin <= 8'h00;
		go_sleep();
		wake_pin <= 8'h02;
		repeat (3) @(posedge ref_clk);
		sleep_pin <= 1'b0;
		finish_wake(4, 5);
		wake_pin <= 8'h00;
		cfg.wake_edge <= 1'b1;
		go_sleep();
		sleep_pin <= 1'b0;
		repeat (30) @(posedge ref_clk);
		#1;
		check("edge no pin", ctl.suspended, 1'b1);
		wake_pin <= 8'h04;
		finish_wake(4, 5);
		wake_pin <= 8'h00;
		cfg.wake_edge <= 1'b0;
		cfg.multi_wake <= 1'b0;
	endtask
	task automatic t_handshake();
		cfg.use_handshake <= 1'b1;
		slow <= 1'b1;
		sleep_pin <= 1'b1;
		repeat (10) @(posedge ref_clk);
		#1;
		check("request out", sleep_req, 1'b1);
		check("store before ack", ctl.store_enable, 1'b1);
		wait_bit(SE, 1'b0);
		check("ack given", sleep_ack, 1'b1);
		wait_bit(WS, 1'b0);
		sleep_pin <= 1'b0;
		finish_wake(4, 5);
		slow <= 1'b0;
	endtask
	task automatic t_reconfig();
		go_sleep();
		reconfig_n <= 1'b0;
		sleep_pin <= 1'b0;
		@(posedge ref_clk);
		#1;
		check("ctl in reconfig", ctl, 6'h00);
		reconfig_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		#1;
		check("awake after reconfig", ctl.wake_status, 1'b1);
		check("store after reconfig", ctl.store_enable, 1'b1);
	endtask
	initial
	begin
		cycles = 0;
		fails = 0;
		total_checks = 0;
		seen_init = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		reconfig_n = 1'b1;
		sleep_pin = 1'b0;
		wake_pin = 8'h00;
		status_reserved = 1'b1;
		slow = 1'b0;
		cfg = '{sleep_off, 1'b0, 8'hff, 1'b0, 1'b0, 1'b0, 11'h004, 11'h005};
		// Pins 1 and 2 take different suspend modes, hiz_plain and hiz_pull_high
		pin_mode = {hiz_bus_hold, hiz_pull_low, hiz_pull_high, hiz_plain, drive_last};
		user_out = 5'h01;
		user_oe_n = 5'h00;
		diff_out = 2'h1;
		diff_oe_n = 2'h0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		t_disabled();
		t_outputs();
		t_counts();
		t_multi();
		t_handshake();
		t_reconfig();
		test_done();
	end
endmodule
